//--- src/fifo_status_tx_length.sv
`timescale 1ns/10ps
module fifo_status_tx_length
	import fifo_len_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// Chip state
	input  wire logic              chip_enable,
	input  wire logic              tx_eof,
	// Receive side filling the FIFO
	input  wire logic              rx_valid,
	input  wire logic [DATA_W-1:0] rx_data,
	// Transmit framing view of the length
	output logic [COUNT_W-1:0]     tx_full_bytes,
	output logic [2:0]             tx_last_bits,
	// Register side
	fifo_len_if.device             bus
);
	// Storage and state
	logic [DATA_W-1:0]  mem [0:126];
	logic [6:0]         wr_ptr;
	logic [6:0]         rd_ptr;
	logic [LEVEL_W-1:0] level;
	logic               overflow;
	logic [7:0]         tx_high;
	logic [7:0]         tx_low;
	logic               chip_en_s1;
	logic               chip_en_s2;

	// 127 slots is not a power of two, so the pointers wrap by hand
	function automatic logic [6:0] wrap_inc(input logic [6:0] ptr);
		logic [6:0] step;
		step = ptr + 7'h01;
		if (ptr == 7'h7E) begin
			step = 7'h00;
		end
		return step;
	endfunction

	// Clear beats a host write in the same cycle
	function automatic logic [7:0] len_next(input logic clear, input logic write,
		input logic [7:0] wdata, input logic [7:0] cur);
		logic [7:0] value;
		value = cur;
		if (write) begin
			value = wdata;
		end
		if (clear) begin
			value = TX_LEN_RESET;
		end
		return value;
	endfunction

	// Fill state
	wire        fifo_full  = ({1'b0, level} == FIFO_DEPTH);
	wire        fifo_empty = (level == 7'h00);
	wire        do_push    = rx_valid && !fifo_full;
	wire        do_pop     = bus.fifo_rd && !fifo_empty;
	wire        push_lost  = rx_valid && fifo_full;
	wire        len_clear  = !chip_en_s2 || tx_eof;

	// Register selects
	wire        sel_status = (bus.addr == ADDR_FIFO_STATUS);
	wire        sel_high   = (bus.addr == ADDR_TX_HIGH);
	wire        sel_low    = (bus.addr == ADDR_TX_LOW);
	wire        wr_high    = bus.wr && sel_high;
	wire        wr_low     = bus.wr && sel_low;
	wire  [7:0] status_word = {overflow, level};
	// Unmapped offsets read as zero
	wire  [7:0] read_mux =
		sel_status ? status_word :
		sel_high   ? tx_high :
		sel_low    ? tx_low : 8'h00;

	// Next values
	wire  [6:0] next_wr_ptr = wrap_inc(wr_ptr);
	wire  [6:0] next_rd_ptr = wrap_inc(rd_ptr);
	wire  [6:0] next_level  =
		(do_push && !do_pop) ? level + 7'h01 :
		(do_pop && !do_push) ? level - 7'h01 : level;
	// A byte lost to a full FIFO beats the clear by disable
	wire        next_overflow = push_lost || (overflow && chip_en_s2);
	wire  [7:0] next_tx_high  = len_next(len_clear, wr_high, bus.wdata, tx_high);
	wire  [7:0] next_tx_low   = len_next(len_clear, wr_low, bus.wdata, tx_low);
	wire  [7:0] next_fifo_data = do_pop ? mem[rd_ptr] : bus.fifo_data;
	wire  [COUNT_W-1:0] next_full_bytes =
		{tx_high, tx_low[7:LOW_NIBBLE_LSB]};
	wire  [2:0] next_last_bits =
		tx_low[PARTIAL_FLAG_BIT] ? tx_low[3:PARTIAL_LSB] : 3'h0;

	// Chip enable comes from a pin
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			chip_en_s1 <= 1'b0;
			chip_en_s2 <= 1'b0;
		end else begin
			chip_en_s1 <= chip_enable;
			chip_en_s2 <= chip_en_s1;
		end
	end

	// No reset on storage: level and pointers say what is valid
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= rx_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= 7'h00;
		end else if (do_push) begin
			wr_ptr <= next_wr_ptr;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_ptr <= 7'h00;
		end else if (do_pop) begin
			rd_ptr <= next_rd_ptr;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			level <= 7'h00;
		end else begin
			level <= next_level;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			overflow <= 1'b0;
		end else begin
			overflow <= next_overflow;
		end
	end

	// Reset, disable or end of frame clear the lengths
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_high <= TX_LEN_RESET;
		end else begin
			tx_high <= next_tx_high;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_low <= TX_LEN_RESET;
		end else begin
			tx_low <= next_tx_low;
		end
	end

	// Read data follows the address; only the cycle with rvalid counts
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus.rdata <= 8'h00;
		end else begin
			bus.rdata <= read_mux;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus.rvalid <= 1'b0;
		end else begin
			bus.rvalid <= bus.rd;
		end
	end

	// Popped byte holds until the next pop
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus.fifo_data <= 8'h00;
		end else begin
			bus.fifo_data <= next_fifo_data;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_full_bytes <= 12'h000;
		end else begin
			tx_full_bytes <= next_full_bytes;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tx_last_bits <= 3'h0;
		end else begin
			tx_last_bits <= next_last_bits;
		end
	end
endmodule

//--- src/fifo_len_pkg.sv
package fifo_len_pkg;
	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 8;
	localparam int          LEVEL_W      = 7;
	localparam int          COUNT_W      = 12;
	localparam logic [7:0]  FIFO_DEPTH   = 8'h7F;
	// Register offsets on the transceiver side
	localparam logic [7:0]  ADDR_FIFO_STATUS = 8'h1C;
	localparam logic [7:0]  ADDR_TX_HIGH     = 8'h1D;
	localparam logic [7:0]  ADDR_TX_LOW      = 8'h1E;
	// Field positions
	localparam int          OVERFLOW_BIT     = 7;
	localparam int          PARTIAL_FLAG_BIT = 0;
	localparam int          PARTIAL_LSB      = 1;
	localparam int          LOW_NIBBLE_LSB   = 4;
	localparam logic [7:0]  TX_LEN_RESET     = 8'h00;
	// Controller's own registers, reached over its command port
	localparam logic [3:0]  CTL_STATUS   = 4'h0;
	localparam logic [3:0]  CTL_MASK     = 4'h1;
	localparam logic [3:0]  CTL_COUNT    = 4'h2;
	localparam logic [3:0]  CTL_PARTIAL  = 4'h3;
	localparam logic [3:0]  CTL_LEVEL    = 4'h4;
	localparam logic [3:0]  CTL_CMD      = 4'h5;
	localparam logic [3:0]  CTL_RXDATA   = 4'h6;
	localparam int          EV_DONE      = 0;
	localparam int          EV_OVERFLOW  = 1;
	localparam logic [1:0]  EV_RESET     = 2'h0;

	function automatic logic [7:0] len_high(input logic [11:0] n);
		return n[11:4];
	endfunction

	function automatic logic [7:0] len_low(input logic [3:0] n, input logic [2:0] bits,
		input logic flag);
		return {n, bits, flag};
	endfunction
endpackage

//--- src/fifo_len_if.sv
`timescale 1ns/10ps
interface fifo_len_if;
	import fifo_len_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic              fifo_rd;
	logic [DATA_W-1:0] rdata;
	logic              rvalid;
	logic [DATA_W-1:0] fifo_data;

	modport device (input addr, wdata, wr, rd, fifo_rd, output rdata, rvalid, fifo_data);
	modport host   (output addr, wdata, wr, rd, fifo_rd, input rdata, rvalid, fifo_data);
endinterface

//--- src/fifo_len_host.sv
`timescale 1ns/10ps
module fifo_len_host
	import fifo_len_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Command port
	input  wire logic [3:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	output logic      [7:0]  cmd_rdata,
	// Interrupt
	output logic             irq,
	// Device side
	fifo_len_if.host         dev
);
	typedef enum logic [1:0] {IDLE = 2'b00, WR_HI = 2'b01, WR_LO = 2'b11, POLL = 2'b10} st_t;
	st_t         state;
	logic [11:0] count;
	logic [3:0]  partial;
	logic [1:0]  status;
	logic [1:0]  mask;
	logic [6:0]  level;
	logic [7:0]  rx_byte;
	logic        pop_wait;

	wire  go       = cmd_wr && (cmd_addr == CTL_CMD) && cmd_wdata[0];
	wire  pop      = cmd_wr && (cmd_addr == CTL_CMD) && cmd_wdata[1];
	wire  clr_w    = cmd_wr && (cmd_addr == CTL_STATUS);
	wire  ev_done  = (state == WR_LO);
	wire  ev_ovf   = dev.rvalid && dev.rdata[OVERFLOW_BIT];
	wire  [1:0] ev = {ev_ovf, ev_done};
	wire  [1:0] next_status = ev | (status & ~(clr_w ? cmd_wdata[1:0] : 2'h0));
	wire  [7:0] rd_mux =
		(cmd_addr == CTL_STATUS)  ? {6'h00, status} :
		(cmd_addr == CTL_MASK)    ? {6'h00, mask} :
		(cmd_addr == CTL_COUNT)   ? count[11:4] :
		(cmd_addr == CTL_PARTIAL) ? {count[3:0], partial} :
		(cmd_addr == CTL_LEVEL)   ? {1'b0, level} :
		(cmd_addr == CTL_RXDATA)  ? rx_byte : 8'h00;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= IDLE;
			status <= EV_RESET;
			mask <= EV_RESET;
			count <= 12'h000;
			partial <= 4'h0;
			level <= 7'h00;
			rx_byte <= 8'h00;
			pop_wait <= 1'b0;
			irq <= 1'b0;
			cmd_rdata <= 8'h00;
			dev.addr <= 8'h00;
			dev.wdata <= 8'h00;
			dev.wr <= 1'b0;
			dev.rd <= 1'b0;
			dev.fifo_rd <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & ~mask);
			cmd_rdata <= cmd_rd ? rd_mux : 8'h00;
			dev.wr <= 1'b0;
			dev.rd <= 1'b0;
			dev.fifo_rd <= pop;
			// The popped byte appears a cycle after the pop strobe
			pop_wait <= dev.fifo_rd;
			if (pop_wait)
				rx_byte <= dev.fifo_data;
			if (cmd_wr && cmd_addr == CTL_MASK)
				mask <= cmd_wdata[1:0];
			if (cmd_wr && cmd_addr == CTL_COUNT)
				count[11:4] <= cmd_wdata;
			if (cmd_wr && cmd_addr == CTL_PARTIAL) begin
				count[3:0] <= cmd_wdata[7:4];
				partial <= cmd_wdata[3:0];
			end
			if (dev.rvalid)
				level <= dev.rdata[6:0];
			unique case (state)
				IDLE: begin
					if (go)
						state <= WR_HI;
				end
				WR_HI: begin
					dev.wr <= 1'b1;
					dev.addr <= ADDR_TX_HIGH;
					dev.wdata <= len_high(count);
					state <= WR_LO;
				end
				WR_LO: begin
					dev.wr <= 1'b1;
					dev.addr <= ADDR_TX_LOW;
					dev.wdata <= len_low(count[3:0], partial[3:1], partial[0]);
					state <= POLL;
				end
				POLL: begin
					dev.rd <= 1'b1;
					dev.addr <= ADDR_FIFO_STATUS;
					state <= IDLE;
				end
			endcase
		end
	end
endmodule

//--- tb/fifo_len_checker.sv
`timescale 1ns/10ps
module fifo_len_checker
	import fifo_len_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// Host to device
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	input  wire logic              fifo_rd,
	// Device to host
	input  wire logic [DATA_W-1:0] rdata,
	input  wire logic              rvalid,
	input  wire logic [DATA_W-1:0] fifo_data
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence hi_wr; wr && addr == ADDR_TX_HIGH; endsequence
	sequence lo_wr; wr && addr == ADDR_TX_LOW; endsequence
	sequence st_rd; rd && addr == ADDR_FIFO_STATUS; endsequence
	AST_RD_ANSWER: assert property (rd |=> rvalid)
		else $error("read not answered");
	AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
		else $error("rvalid without read");
	AST_HI_THEN_LO: assert property (hi_wr |=> lo_wr)
		else $error("low length byte not sent");
	AST_LO_AFTER_HI: assert property (lo_wr |-> $past(wr && addr == ADDR_TX_HIGH))
		else $error("low length byte without high");
	AST_STATUS_AFTER: assert property (hi_wr ##1 lo_wr |=> st_rd)
		else $error("status not read after lengths");
	AST_NO_RO_WRITE: assert property (wr |-> addr != ADDR_FIFO_STATUS)
		else $error("write to read-only status");
	AST_STROBES_APART: assert property (!(wr && rd))
		else $error("write and read together");
	AST_FIFO_DATA_HOLD: assert property (!$past(fifo_rd) |-> $stable(fifo_data))
		else $error("fifo data moved without pop");
endmodule

//--- tb/fifo_status_tx_length_bench.sv
`timescale 1ns/10ps
module fifo_status_tx_length_bench;
	import fifo_len_pkg::*;
	logic        sys_clk     = 1'b0;
	logic        reset       = 1'b1;
	logic        chip_enable = 1'b1;
	logic        tx_eof      = 1'b0;
	logic        rx_valid    = 1'b0;
	logic [7:0]  rx_data     = 8'h00;
	logic [3:0]  cmd_addr    = 4'h0;
	logic [7:0]  cmd_wdata   = 8'h00;
	logic        cmd_wr      = 1'b0;
	logic        cmd_rd      = 1'b0;
	logic [7:0]  cmd_rdata;
	logic        irq;
	logic [11:0] tx_full_bytes;
	logic [2:0]  tx_last_bits;
	int          errors      = 0;
	int          tests_run   = 0;
	fifo_len_if link ();
	always #4 sys_clk = ~sys_clk;
	fifo_status_tx_length i_fifo_status_tx_length (.sys_clk(sys_clk), .reset(reset),
		.chip_enable(chip_enable), .tx_eof(tx_eof), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_full_bytes(tx_full_bytes), .tx_last_bits(tx_last_bits), .bus(link.device));
	fifo_len_host i_fifo_len_host (.sys_clk(sys_clk), .reset(reset), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.irq(irq), .dev(link.host));
	fifo_len_checker i_fifo_len_checker (.sys_clk(sys_clk), .reset(reset), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .fifo_rd(link.fifo_rd),
		.rdata(link.rdata), .rvalid(link.rvalid), .fifo_data(link.fifo_data));
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic cw(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cmd_wr    <= 1'b1;
		cmd_addr  <= a;
		cmd_wdata <= d;
		@(posedge sys_clk);
		cmd_wr    <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic cr(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge sys_clk);
		cmd_rd   <= 1'b1;
		cmd_addr <= a;
		@(posedge sys_clk);
		cmd_rd   <= 1'b0;
		#1 chk(12'(cmd_rdata & m), 12'(e));
	endtask
	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_data  <= 8'(8'h11 * (i + 1));
		end
		@(posedge sys_clk);
		rx_valid <= 1'b0;
	endtask
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
	initial begin
		idle(12);
		reset <= 1'b0;
		idle(4);
		push(3);
		cw(CTL_COUNT, 8'hAB);
		cw(CTL_PARTIAL, 8'hCB);
		cw(CTL_MASK, 8'h03);
		cw(CTL_CMD, 8'h01);
		idle(10);
		chk(tx_full_bytes, 12'hABC);
		chk(12'(tx_last_bits), 12'h005);
		cr(CTL_LEVEL, 8'h03, 8'h7F);
		cr(CTL_STATUS, 8'h01, 8'hFF);
		chk(12'(irq), 12'h000);
		cw(CTL_MASK, 8'h00);
		idle(2);
		chk(12'(irq), 12'h001);
		cw(CTL_STATUS, 8'h01);
		idle(2);
		chk(12'(irq), 12'h000);
		cw(CTL_CMD, 8'h02);
		idle(5);
		cr(CTL_RXDATA, 8'h11, 8'hFF);
		// Flag clear: the bit count must be ignored
		cw(CTL_PARTIAL, 8'h5A);
		cw(CTL_CMD, 8'h01);
		idle(10);
		chk(tx_full_bytes, 12'hAB5);
		chk(12'(tx_last_bits), 12'h000);
		cr(CTL_LEVEL, 8'h02, 8'h7F);
		@(posedge sys_clk);
		tx_eof <= 1'b1;
		@(posedge sys_clk);
		tx_eof <= 1'b0;
		idle(3);
		chk(tx_full_bytes, 12'h000);
		push(130);
		cw(CTL_STATUS, 8'h03);
		cw(CTL_CMD, 8'h01);
		idle(10);
		cr(CTL_STATUS, 8'h03, 8'hFF);
		cr(CTL_LEVEL, 8'h7F, 8'h7F);
		@(posedge sys_clk);
		chip_enable <= 1'b0;
		idle(4);
		chip_enable <= 1'b1;
		idle(4);
		chk(tx_full_bytes, 12'h000);
		cw(CTL_STATUS, 8'h03);
		cw(CTL_CMD, 8'h01);
		idle(10);
		cr(CTL_STATUS, 8'h01, 8'hFF);
		give_verdict();
	end
endmodule
